// ===== rtl/didc_pkg.sv
/*
  Constants for the digital input command decoder: terminal count, code
  layout, function indices, link word bit pairing and block classes.
  Assumes a single clock domain and the function codes held as plain
  binary integers.
*/
package didc_pkg;

  localparam int unsigned NTERM     = 7;
  localparam int unsigned NFUNC     = 31;
  localparam int unsigned CODE_W    = 11;
  localparam int unsigned IDX_W     = 5;
  localparam int unsigned LINK_W    = 16;

  localparam logic [CODE_W-1:0] CODE_OFF_BASE = 11'h3E8;
  localparam logic [CODE_W-1:0] CODE_LIMIT    = 11'h7D0;

  // Terminal order used for every array
  localparam int unsigned T_IN1 = 0;
  localparam int unsigned T_IN2 = 1;
  localparam int unsigned T_IN3 = 2;
  localparam int unsigned T_IN4 = 3;
  localparam int unsigned T_IN5 = 4;
  localparam int unsigned T_FWD = 5;
  localparam int unsigned T_REV = 6;

  // Link word bit paired with each terminal
  localparam logic [3:0] LINK_BIT_IN1 = 4'h2;
  localparam logic [3:0] LINK_BIT_IN2 = 4'h3;
  localparam logic [3:0] LINK_BIT_IN3 = 4'h4;
  localparam logic [3:0] LINK_BIT_IN4 = 4'h5;
  localparam logic [3:0] LINK_BIT_IN5 = 4'h6;
  localparam logic [3:0] LINK_BIT_FWD = 4'hD;
  localparam logic [3:0] LINK_BIT_REV = 4'hE;

  localparam logic [LINK_W-1:0] LINK_WORD_RESET = 16'h0000;

  // Function indices into the decoded vector
  localparam int unsigned F_SS1    = 0;
  localparam int unsigned F_SS2    = 1;
  localparam int unsigned F_SS4    = 2;
  localparam int unsigned F_HLD    = 3;
  localparam int unsigned F_COAST  = 4;
  localparam int unsigned F_ARST   = 5;
  localparam int unsigned F_TRIP   = 6;
  localparam int unsigned F_FSWAP  = 7;
  localparam int unsigned F_DCB    = 8;
  localparam int unsigned F_BYP50  = 9;
  localparam int unsigned F_BYP60  = 10;
  localparam int unsigned F_UP     = 11;
  localparam int unsigned F_DOWN   = 12;
  localparam int unsigned F_WPERM  = 13;
  localparam int unsigned F_PIDC   = 14;
  localparam int unsigned F_INV    = 15;
  localparam int unsigned F_ILOCK  = 16;
  localparam int unsigned F_LINK   = 17;
  localparam int unsigned F_GPI    = 18;
  localparam int unsigned F_STM    = 19;
  localparam int unsigned F_FSTOP  = 20;
  localparam int unsigned F_PIDCLR = 21;
  localparam int unsigned F_PIDFRZ = 22;
  localparam int unsigned F_PANEL  = 23;
  localparam int unsigned F_RUNOK  = 24;
  localparam int unsigned F_DEW    = 25;
  localparam int unsigned F_SEQ50  = 26;
  localparam int unsigned F_SEQ60  = 27;
  localparam int unsigned F_RSWAP  = 28;
  localparam int unsigned F_SECOND_FORWARD_RUN   = 29;
  localparam int unsigned F_SECOND_BACKWARD_RUN   = 30;

  // Block classes; every function outside both masks is general type
  localparam logic [NFUNC-1:0] TERM_ONLY_MASK = 31'h00832000;
  localparam logic [NFUNC-1:0] OR_TYPE_MASK   = 31'h00100070;

  // Registers between pin sample and decoded outputs
  localparam logic [1:0] WARM_CYCLES = 2'h3;

  // Decoded code: {valid, active_off, index}
  function automatic logic [IDX_W+1:0] didc_decode(input logic [CODE_W-1:0] code);
    logic [CODE_W-1:0] base;
    logic              hi;
    logic              ok;
    logic              inv;
    logic              on_only;
    logic [IDX_W-1:0]  idx;
    hi      = (code >= CODE_OFF_BASE);
    base    = hi ? code - CODE_OFF_BASE : code;
    ok      = (code < CODE_LIMIT);
    inv     = 1'b0;
    on_only = 1'b0;
    idx     = '0;
    unique case (base)
      11'h000: idx = IDX_W'(F_SS1);
      11'h001: idx = IDX_W'(F_SS2);
      11'h002: idx = IDX_W'(F_SS4);
      11'h006: idx = IDX_W'(F_HLD);
      11'h007: idx = IDX_W'(F_COAST);
      11'h008: idx = IDX_W'(F_ARST);
      11'h009: begin idx = IDX_W'(F_TRIP); inv = 1'b1; end
      11'h00B: idx = IDX_W'(F_FSWAP);
      11'h00D: begin idx = IDX_W'(F_DCB); on_only = 1'b1; end
      11'h00F: begin idx = IDX_W'(F_BYP50); on_only = 1'b1; end
      11'h010: begin idx = IDX_W'(F_BYP60); on_only = 1'b1; end
      11'h011: idx = IDX_W'(F_UP);
      11'h012: idx = IDX_W'(F_DOWN);
      11'h013: idx = IDX_W'(F_WPERM);
      11'h014: idx = IDX_W'(F_PIDC);
      11'h015: idx = IDX_W'(F_INV);
      11'h016: idx = IDX_W'(F_ILOCK);
      11'h018: idx = IDX_W'(F_LINK);
      11'h019: idx = IDX_W'(F_GPI);
      11'h01A: idx = IDX_W'(F_STM);
      11'h01E: begin idx = IDX_W'(F_FSTOP); inv = 1'b1; end
      11'h021: idx = IDX_W'(F_PIDCLR);
      11'h022: idx = IDX_W'(F_PIDFRZ);
      11'h023: idx = IDX_W'(F_PANEL);
      11'h026: idx = IDX_W'(F_RUNOK);
      11'h027: begin idx = IDX_W'(F_DEW); on_only = 1'b1; end
      11'h028: begin idx = IDX_W'(F_SEQ50); on_only = 1'b1; end
      11'h029: begin idx = IDX_W'(F_SEQ60); on_only = 1'b1; end
      11'h057: idx = IDX_W'(F_RSWAP);
      11'h058: begin idx = IDX_W'(F_SECOND_FORWARD_RUN); on_only = 1'b1; end
      11'h059: begin idx = IDX_W'(F_SECOND_BACKWARD_RUN); on_only = 1'b1; end
      default: ok = 1'b0;
    endcase
    if (on_only && hi) begin
      ok = 1'b0;
    end
    return {ok, hi ^ inv, idx};
  endfunction

endpackage

// ===== rtl/didc_term_decode.sv
/*
  One input terminal: decodes its function code into a one-hot function
  select and qualifies the terminal level and its link bit.
  Assumes the pin, code and link bit arrive already registered.
*/
`timescale 1ns/1ps
module didc_term_decode (
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire logic [didc_pkg::CODE_W-1:0]      code,
  input  wire logic                             pin,
  input  wire logic                             link_bit,
  output logic      [didc_pkg::NFUNC-1:0]       sel_q,
  output logic                                  term_q,
  output logic                                  link_q
);

  logic [didc_pkg::IDX_W+1:0] dec;
  logic [didc_pkg::NFUNC-1:0] sel_d;
  logic                       term_d;
  logic                       link_d;

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    dec   = didc_pkg::didc_decode(code);
    sel_d = '0;
    if (dec[didc_pkg::IDX_W+1]) begin
      sel_d[dec[didc_pkg::IDX_W-1:0]] = 1'b1;
    end
    term_d = pin ^ dec[didc_pkg::IDX_W];
    link_d = link_bit;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q  <= '0;
      term_q <= 1'b0;
      link_q <= 1'b0;
    end else begin
      sel_q  <= sel_d;
      term_q <= term_d;
      link_q <= link_d;
    end
  end

endmodule

// ===== rtl/didc_decoder.sv
/*
  Digital input command decoder: seven input terminals and the paired
  bits of the link control word become the internal command signals.
  Assumes all inputs are synchronous to CLK and the link word is written
  by a one-cycle strobe from the communications controller.
*/
`timescale 1ns/1ps
// Operation
// - Inputs one to five pair with link bits 2-6, forward 13, backward 14.
// - Each terminal has its own function code, which alone picks its command.
// - Code below 1000 is active-on; same code plus 1000 is active-off.
// - Trip and forced stop invert this: 1009/1030 active-on, 9/30 active-off.
// - Brake, bypass, dew, sequence and second run accept active-on codes only.
// - Codes map to functions per the function table.
// - An assigned terminal raises its select qualifier for that function.
// - Several terminals with one function are ORed together.
// - General functions switch between terminal and link bit as source.
// - Terminal-only functions ignore the link word bits.
// - OR-type functions are on when either terminal or link bit is on.
// - With host link off, qualified terminal signals pass straight through.
module didc_decoder (
  input  wire logic                         CLK,
  input  wire logic                         RST,
  input  wire logic                         DIGITAL_INPUT_1,
  input  wire logic                         DIGITAL_INPUT_2,
  input  wire logic                         DIGITAL_INPUT_3,
  input  wire logic                         DIGITAL_INPUT_4,
  input  wire logic                         DIGITAL_INPUT_5,
  input  wire logic                         FORWARD_RUN_TERMINAL,
  input  wire logic                         BACKWARD_RUN_TERMINAL,
  input  wire logic [didc_pkg::CODE_W-1:0]  INPUT1_FUNCTION_CODE,
  input  wire logic [didc_pkg::CODE_W-1:0]  INPUT2_FUNCTION_CODE,
  input  wire logic [didc_pkg::CODE_W-1:0]  INPUT3_FUNCTION_CODE,
  input  wire logic [didc_pkg::CODE_W-1:0]  INPUT4_FUNCTION_CODE,
  input  wire logic [didc_pkg::CODE_W-1:0]  INPUT5_FUNCTION_CODE,
  input  wire logic [didc_pkg::CODE_W-1:0]  FORWARD_PIN_CODE,
  input  wire logic [didc_pkg::CODE_W-1:0]  BACKWARD_PIN_CODE,
  input  wire logic [didc_pkg::LINK_W-1:0]  LINK_CONTROL_WORD,
  input  wire logic                         LINK_CONTROL_WORD_WE,
  output logic                              STEP_SPEED_BIT0,
  output logic                              STEP_SPEED_BIT1,
  output logic                              STEP_SPEED_BIT2,
  output logic                              THREE_WIRE_HOLD,
  output logic                              COAST_STOP,
  output logic                              ALARM_RESET,
  output logic                              EXTERNAL_TRIP,
  output logic                              FREQ_SOURCE_SWAP,
  output logic                              DC_BRAKE_REQUEST,
  output logic                              MAINS_BYPASS_50,
  output logic                              MAINS_BYPASS_60,
  output logic                              FREQ_UP,
  output logic                              FREQ_DOWN,
  output logic                              PANEL_WRITE_PERMIT,
  output logic                              PID_CANCEL,
  output logic                              INVERSE_ACTION_SWAP,
  output logic                              INTERLOCK_INPUT,
  output logic                              HOST_LINK_ON,
  output logic                              GENERAL_PURPOSE_INPUT,
  output logic                              START_MODE_PICK,
  output logic                              FORCE_STOP,
  output logic                              PID_CLEAR_ID,
  output logic                              PID_FREEZE_I,
  output logic                              PANEL_OWN_MODE,
  output logic                              RUN_PERMIT,
  output logic                              DEW_GUARD,
  output logic                              AUTO_MAINS_SEQ_50,
  output logic                              AUTO_MAINS_SEQ_60,
  output logic                              RUN_SOURCE_SWAP,
  output logic                              SECOND_FORWARD_RUN,
  output logic                              SECOND_BACKWARD_RUN
);

  localparam int unsigned NT = didc_pkg::NTERM;
  localparam int unsigned NF = didc_pkg::NFUNC;

  logic [NT-1:0]                     pin_d;
  logic [NT-1:0]                     pin_q;
  logic [didc_pkg::CODE_W-1:0]       code_d [NT];
  logic [didc_pkg::CODE_W-1:0]       code_q [NT];
  logic [didc_pkg::LINK_W-1:0]       link_word_d;
  logic [didc_pkg::LINK_W-1:0]       link_word_q;
  logic [NT-1:0]                     link_bit;
  logic [NF-1:0]                     sel    [NT];
  logic [NT-1:0]                     term;
  logic [NT-1:0]                     link;
  logic [NF-1:0]                     term_or;
  logic [NF-1:0]                     link_or;
  logic                              link_on;
  logic [NF-1:0]                     func_d;
  logic [NF-1:0]                     func_q;
  logic [NF-1:0]                     out_d;
  logic [1:0]                        warm_d;
  logic [1:0]                        warm_q;

  //////////////////////////////////////////////////////////////////////////
  // Input sampling and link word register

  always_comb begin
    pin_d[didc_pkg::T_IN1] = DIGITAL_INPUT_1;
    pin_d[didc_pkg::T_IN2] = DIGITAL_INPUT_2;
    pin_d[didc_pkg::T_IN3] = DIGITAL_INPUT_3;
    pin_d[didc_pkg::T_IN4] = DIGITAL_INPUT_4;
    pin_d[didc_pkg::T_IN5] = DIGITAL_INPUT_5;
    pin_d[didc_pkg::T_FWD] = FORWARD_RUN_TERMINAL;
    pin_d[didc_pkg::T_REV] = BACKWARD_RUN_TERMINAL;
    code_d[didc_pkg::T_IN1] = INPUT1_FUNCTION_CODE;
    code_d[didc_pkg::T_IN2] = INPUT2_FUNCTION_CODE;
    code_d[didc_pkg::T_IN3] = INPUT3_FUNCTION_CODE;
    code_d[didc_pkg::T_IN4] = INPUT4_FUNCTION_CODE;
    code_d[didc_pkg::T_IN5] = INPUT5_FUNCTION_CODE;
    code_d[didc_pkg::T_FWD] = FORWARD_PIN_CODE;
    code_d[didc_pkg::T_REV] = BACKWARD_PIN_CODE;
    link_word_d = LINK_CONTROL_WORD_WE ? LINK_CONTROL_WORD : link_word_q;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_q       <= '0;
      link_word_q <= didc_pkg::LINK_WORD_RESET;
      for (int i = 0; i < NT; i++) begin
        code_q[i] <= '0;
      end
    end else begin
      pin_q       <= pin_d;
      link_word_q <= link_word_d;
      for (int i = 0; i < NT; i++) begin
        code_q[i] <= code_d[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Terminal to link bit pairing

  always_comb begin
    link_bit[didc_pkg::T_IN1] = link_word_q[didc_pkg::LINK_BIT_IN1];
    link_bit[didc_pkg::T_IN2] = link_word_q[didc_pkg::LINK_BIT_IN2];
    link_bit[didc_pkg::T_IN3] = link_word_q[didc_pkg::LINK_BIT_IN3];
    link_bit[didc_pkg::T_IN4] = link_word_q[didc_pkg::LINK_BIT_IN4];
    link_bit[didc_pkg::T_IN5] = link_word_q[didc_pkg::LINK_BIT_IN5];
    link_bit[didc_pkg::T_FWD] = link_word_q[didc_pkg::LINK_BIT_FWD];
    link_bit[didc_pkg::T_REV] = link_word_q[didc_pkg::LINK_BIT_REV];
  end

  //////////////////////////////////////////////////////////////////////////
  // Per terminal decode

  for (genvar t = 0; t < NT; t++) begin : g_term
    didc_term_decode u_dec (
      .clk      (CLK),
      .rst      (RST),
      .code     (code_q[t]),
      .pin      (pin_q[t]),
      .link_bit (link_bit[t]),
      .sel_q    (sel[t]),
      .term_q   (term[t]),
      .link_q   (link[t])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // Function combining

  always_comb begin
    term_or = '0;
    link_or = '0;
    // OR of terminals sharing a function
    for (int t = 0; t < NT; t++) begin
      term_or = term_or | (sel[t] & {NF{term[t]}});
      link_or = link_or | (sel[t] & {NF{link[t]}});
    end
    // Link enable itself comes from terminals only, so it cannot lock itself out
    link_on = term_or[didc_pkg::F_LINK];
    for (int f = 0; f < NF; f++) begin
      if (didc_pkg::TERM_ONLY_MASK[f]) begin
        func_d[f] = term_or[f];
      end else if (didc_pkg::OR_TYPE_MASK[f]) begin
        func_d[f] = term_or[f] | link_or[f];
      end else begin
        func_d[f] = link_on ? link_or[f] : term_or[f];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output register and warm-up gate

  always_comb begin
    warm_d = (warm_q == didc_pkg::WARM_CYCLES) ? warm_q : warm_q + 2'h1;
    out_d  = (warm_q == didc_pkg::WARM_CYCLES) ? func_d : '0;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      warm_q <= '0;
      func_q <= '0;
    end else begin
      warm_q <= warm_d;
      func_q <= out_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Command outputs

  always_comb begin
    STEP_SPEED_BIT0       = func_q[didc_pkg::F_SS1];
    STEP_SPEED_BIT1       = func_q[didc_pkg::F_SS2];
    STEP_SPEED_BIT2       = func_q[didc_pkg::F_SS4];
    THREE_WIRE_HOLD       = func_q[didc_pkg::F_HLD];
    COAST_STOP            = func_q[didc_pkg::F_COAST];
    ALARM_RESET           = func_q[didc_pkg::F_ARST];
    EXTERNAL_TRIP         = func_q[didc_pkg::F_TRIP];
    FREQ_SOURCE_SWAP      = func_q[didc_pkg::F_FSWAP];
    DC_BRAKE_REQUEST      = func_q[didc_pkg::F_DCB];
    MAINS_BYPASS_50       = func_q[didc_pkg::F_BYP50];
    MAINS_BYPASS_60       = func_q[didc_pkg::F_BYP60];
    FREQ_UP               = func_q[didc_pkg::F_UP];
    FREQ_DOWN             = func_q[didc_pkg::F_DOWN];
    PANEL_WRITE_PERMIT    = func_q[didc_pkg::F_WPERM];
    PID_CANCEL            = func_q[didc_pkg::F_PIDC];
    INVERSE_ACTION_SWAP   = func_q[didc_pkg::F_INV];
    INTERLOCK_INPUT       = func_q[didc_pkg::F_ILOCK];
    HOST_LINK_ON          = func_q[didc_pkg::F_LINK];
    GENERAL_PURPOSE_INPUT = func_q[didc_pkg::F_GPI];
    START_MODE_PICK       = func_q[didc_pkg::F_STM];
    FORCE_STOP            = func_q[didc_pkg::F_FSTOP];
    PID_CLEAR_ID          = func_q[didc_pkg::F_PIDCLR];
    PID_FREEZE_I          = func_q[didc_pkg::F_PIDFRZ];
    PANEL_OWN_MODE        = func_q[didc_pkg::F_PANEL];
    RUN_PERMIT            = func_q[didc_pkg::F_RUNOK];
    DEW_GUARD             = func_q[didc_pkg::F_DEW];
    AUTO_MAINS_SEQ_50     = func_q[didc_pkg::F_SEQ50];
    AUTO_MAINS_SEQ_60     = func_q[didc_pkg::F_SEQ60];
    RUN_SOURCE_SWAP       = func_q[didc_pkg::F_RSWAP];
    SECOND_FORWARD_RUN    = func_q[didc_pkg::F_SECOND_FORWARD_RUN];
    SECOND_BACKWARD_RUN   = func_q[didc_pkg::F_SECOND_BACKWARD_RUN];
  end

endmodule

// ===== dv/didc_decoder_chk.sv
/*
  Checker for the digital input command decoder, bound to its top module.
  Assumes pins, codes and the link word each pass three registers, so
  their effect is seen at the ports three samples after their cause.
*/
`timescale 1ns/1ps
module didc_decoder_chk (
  input wire logic                        CLK,
  input wire logic                        RST,
  input wire logic                        DIGITAL_INPUT_1,
  input wire logic                        DIGITAL_INPUT_2,
  input wire logic [didc_pkg::CODE_W-1:0] INPUT1_FUNCTION_CODE,
  input wire logic [didc_pkg::CODE_W-1:0] INPUT2_FUNCTION_CODE,
  input wire logic [didc_pkg::CODE_W-1:0] INPUT3_FUNCTION_CODE,
  input wire logic [didc_pkg::CODE_W-1:0] INPUT4_FUNCTION_CODE,
  input wire logic [didc_pkg::CODE_W-1:0] INPUT5_FUNCTION_CODE,
  input wire logic [didc_pkg::CODE_W-1:0] FORWARD_PIN_CODE,
  input wire logic [didc_pkg::CODE_W-1:0] BACKWARD_PIN_CODE,
  input wire logic [didc_pkg::LINK_W-1:0] LINK_CONTROL_WORD,
  input wire logic                        LINK_CONTROL_WORD_WE,
  input wire logic                        STEP_SPEED_BIT0,
  input wire logic                        STEP_SPEED_BIT1,
  input wire logic                        COAST_STOP,
  input wire logic                        ALARM_RESET,
  input wire logic                        EXTERNAL_TRIP,
  input wire logic                        DC_BRAKE_REQUEST,
  input wire logic                        HOST_LINK_ON
);
  logic [2:0]       warm_q;
  logic [2:0]       warm_d;
  logic [6:0][10:0] codes;
  logic             any_brake;
  logic             any_link;

  assign codes = {BACKWARD_PIN_CODE, FORWARD_PIN_CODE, INPUT5_FUNCTION_CODE, INPUT4_FUNCTION_CODE,
                  INPUT3_FUNCTION_CODE, INPUT2_FUNCTION_CODE, INPUT1_FUNCTION_CODE};

  // Saturates at 5 so a full pipeline is known
  always_comb begin
    warm_d = (warm_q == 3'h5) ? warm_q : warm_q + 3'h1;
  end

  always_ff @(posedge CLK) begin
    warm_q <= RST ? 3'h0 : warm_d;
  end

  always_comb begin
    any_brake = 1'b0;
    any_link  = 1'b0;
    for (int i = 0; i < 7; i++) begin
      any_brake = any_brake | (codes[i] == 11'h00D);
      any_link  = any_link | (codes[i] == 11'h018) | (codes[i] == 11'h400);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  warm_hold_a: assert property (warm_q < 3'h4 |-> !(STEP_SPEED_BIT0 | STEP_SPEED_BIT1 | COAST_STOP |
    ALARM_RESET | EXTERNAL_TRIP | DC_BRAKE_REQUEST | HOST_LINK_ON)) else $error("output high while warming");
  coast_on_a: assert property (warm_q == 3'h5 && INPUT1_FUNCTION_CODE == 11'h007 && DIGITAL_INPUT_1
    |-> ##3 COAST_STOP) else $error("coast stop missing");
  polarity_off_a: assert property (warm_q == 3'h5 && INPUT2_FUNCTION_CODE == 11'h3EF && !DIGITAL_INPUT_2
    |-> ##3 COAST_STOP) else $error("active-off coast stop missing");
  trip_invert_a: assert property (warm_q == 3'h5 && INPUT1_FUNCTION_CODE == 11'h3F1 && DIGITAL_INPUT_1
    |-> ##3 EXTERNAL_TRIP) else $error("external trip missing");
  brake_code_a: assert property (DC_BRAKE_REQUEST |-> $past(any_brake, 3))
    else $error("brake without its code");
  link_or_a: assert property (warm_q == 3'h5 && LINK_CONTROL_WORD_WE && LINK_CONTROL_WORD[2]
    && INPUT1_FUNCTION_CODE == 11'h007 |-> ##3 COAST_STOP) else $error("link coast stop missing");
  bit_pairing_a: assert property (warm_q == 3'h5 && LINK_CONTROL_WORD_WE && LINK_CONTROL_WORD[13]
    && FORWARD_PIN_CODE == 11'h008 |-> ##3 ALARM_RESET) else $error("forward link bit not paired");
  link_general_a: assert property (warm_q == 3'h5 && LINK_CONTROL_WORD_WE && LINK_CONTROL_WORD[3]
    && INPUT1_FUNCTION_CODE == 11'h018 && DIGITAL_INPUT_1 && INPUT2_FUNCTION_CODE == 11'h000
    |-> ##3 STEP_SPEED_BIT0) else $error("link source not taken");
  pass_through_a: assert property (warm_q == 3'h5 && !any_link && INPUT1_FUNCTION_CODE == 11'h001
    && DIGITAL_INPUT_1 |-> ##3 STEP_SPEED_BIT1) else $error("terminal not passed through");
endmodule

bind didc_decoder didc_decoder_chk i_chk (.*);

// ===== dv/didc_far_side.sv
/*
  Contacts and host link controller beside the decoder.
  Assumes requests are set between edges; drives one small delay after CLK.
*/
`timescale 1ns/1ps
module didc_far_side (
  input  wire logic        clk,
  input  wire logic [6:0]  pin_req,
  input  wire logic [15:0] word_req,
  input  wire logic        word_go,
  output logic      [6:0]  pins,
  output logic      [15:0] word,
  output logic             word_we
);
  logic [6:0]  pin_s;
  logic [15:0] word_s;
  logic        go_s;

  initial begin
    pins    = 7'h00;
    word    = 16'h0000;
    word_we = 1'b0;
  end

  // paired bits held only while strobed
  always @(posedge clk) begin
    pin_s  = pin_req;
    word_s = word_req;
    go_s   = word_go;
    #1;
    pins    = pin_s;
    word_we = go_s;
    // Released bus toggles so stale data is never mistaken for a write
    word = go_s ? word_s : ~word;
  end
endmodule

// ===== dv/testbench.sv
/*
  Self-checking bench for the decoder, compared against a model.
  Assumes the far-side model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module testbench;
  localparam int FC [31] = '{0, 1, 2, 6, 7, 8, 9, 11, 13, 15, 16, 17, 18, 19, 20, 21, 22, 24, 25, 26, 30, 33,
                             34, 35, 38, 39, 40, 41, 87, 88, 89};
  localparam int LB [7]  = '{2, 3, 4, 5, 6, 13, 14};

  logic CLK = 1'b0;
  logic RST;
  logic DIGITAL_INPUT_1, DIGITAL_INPUT_2, DIGITAL_INPUT_3, DIGITAL_INPUT_4, DIGITAL_INPUT_5;
  logic FORWARD_RUN_TERMINAL, BACKWARD_RUN_TERMINAL, LINK_CONTROL_WORD_WE;
  logic [didc_pkg::CODE_W-1:0] INPUT1_FUNCTION_CODE, INPUT2_FUNCTION_CODE, INPUT3_FUNCTION_CODE;
  logic [didc_pkg::CODE_W-1:0] INPUT4_FUNCTION_CODE, INPUT5_FUNCTION_CODE, FORWARD_PIN_CODE, BACKWARD_PIN_CODE;
  logic [didc_pkg::LINK_W-1:0] LINK_CONTROL_WORD;
  logic STEP_SPEED_BIT0, STEP_SPEED_BIT1, STEP_SPEED_BIT2, THREE_WIRE_HOLD, COAST_STOP, ALARM_RESET;
  logic EXTERNAL_TRIP, FREQ_SOURCE_SWAP, DC_BRAKE_REQUEST, MAINS_BYPASS_50, MAINS_BYPASS_60, FREQ_UP;
  logic FREQ_DOWN, PANEL_WRITE_PERMIT, PID_CANCEL, INVERSE_ACTION_SWAP, INTERLOCK_INPUT, HOST_LINK_ON;
  logic GENERAL_PURPOSE_INPUT, START_MODE_PICK, FORCE_STOP, PID_CLEAR_ID, PID_FREEZE_I, PANEL_OWN_MODE;
  logic RUN_PERMIT, DEW_GUARD, AUTO_MAINS_SEQ_50, AUTO_MAINS_SEQ_60, RUN_SOURCE_SWAP;
  logic SECOND_FORWARD_RUN, SECOND_BACKWARD_RUN;
  logic [30:0]      outv;
  logic [6:0]       pins;
  logic [6:0]       pin_req;
  logic [15:0]      word_req;
  logic             word_go;
  logic [6:0][10:0] code;
  logic [6:0][10:0] c;
  logic [6:0]       p;
  int               fail_count;
  int               check_count;

  assign {BACKWARD_RUN_TERMINAL, FORWARD_RUN_TERMINAL, DIGITAL_INPUT_5, DIGITAL_INPUT_4, DIGITAL_INPUT_3,
          DIGITAL_INPUT_2, DIGITAL_INPUT_1} = pins;
  assign {BACKWARD_PIN_CODE, FORWARD_PIN_CODE, INPUT5_FUNCTION_CODE, INPUT4_FUNCTION_CODE, INPUT3_FUNCTION_CODE,
          INPUT2_FUNCTION_CODE, INPUT1_FUNCTION_CODE} = code;
  assign outv = {SECOND_BACKWARD_RUN, SECOND_FORWARD_RUN, RUN_SOURCE_SWAP, AUTO_MAINS_SEQ_60, AUTO_MAINS_SEQ_50,
                 DEW_GUARD, RUN_PERMIT, PANEL_OWN_MODE, PID_FREEZE_I, PID_CLEAR_ID, FORCE_STOP, START_MODE_PICK,
                 GENERAL_PURPOSE_INPUT, HOST_LINK_ON, INTERLOCK_INPUT, INVERSE_ACTION_SWAP, PID_CANCEL,
                 PANEL_WRITE_PERMIT, FREQ_DOWN, FREQ_UP, MAINS_BYPASS_60, MAINS_BYPASS_50, DC_BRAKE_REQUEST,
                 FREQ_SOURCE_SWAP, EXTERNAL_TRIP, ALARM_RESET, COAST_STOP, THREE_WIRE_HOLD, STEP_SPEED_BIT2,
                 STEP_SPEED_BIT1, STEP_SPEED_BIT0};

  always #10 CLK = ~CLK;

  didc_decoder i_dut (.*);
  didc_far_side i_far (.clk(CLK), .pin_req(pin_req), .word_req(word_req), .word_go(word_go), .pins(pins),
                       .word(LINK_CONTROL_WORD), .word_we(LINK_CONTROL_WORD_WE));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [30:0] model(input logic [6:0][10:0] cv, input logic [6:0] pv, input logic [15:0] w);
    logic [30:0] t;
    logic [30:0] l;
    logic [30:0] r;
    int          b;
    int          f;
    t = '0;
    l = '0;
    for (int i = 0; i < 7; i++) begin
      b = (cv[i] >= 1000) ? cv[i] - 1000 : cv[i];
      f = -1;
      for (int j = 0; j < 31; j++) begin
        if (FC[j] == b) f = j;
      end
      // On-only functions refuse the plus-1000 code
      if (cv[i] < 2000 && f >= 0 && !(31'h6E000700 >> f & (cv[i] >= 1000))) begin
        t[f] = t[f] | (pv[i] ^ (cv[i] >= 1000) ^ (31'h00100040 >> f & 1));
        l[f] = l[f] | w[LB[i]];
      end
    end
    for (int k = 0; k < 31; k++) begin
      if (31'h00832000 >> k & 1) r[k] = t[k];
      else if (31'h00100070 >> k & 1) r[k] = t[k] | l[k];
      else r[k] = t[17] ? l[k] : t[k];
    end
    return r;
  endfunction

  function automatic logic [10:0] rcode();
    return 11'((($urandom % 8) == 0) ? $urandom % 2048 : FC[$urandom % 31] + 1000 * ($urandom % 2));
  endfunction

  task automatic check(input string name, input logic [30:0] exp, input logic [30:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic step(input logic [6:0][10:0] cv, input logic [6:0] pv, input logic [15:0] w);
    @(posedge CLK);
    #1;
    code = cv;
    pin_req = pv;
    word_req = w;
    word_go = 1'b1;
    @(posedge CLK);
    #1;
    word_go = 1'b0;
    // Link, pin and code paths are equal: three registers after the write
    repeat (5) @(posedge CLK);
    #2;
    check("decoded outputs", model(cv, pv, w), outv);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    RST = 1'b1;
    code = '0;
    pin_req = '0;
    word_req = '0;
    word_go = 1'b0;
    fail_count = 0;
    check_count = 0;
    void'($urandom(32'h89AF33F4));
    repeat (3) @(posedge CLK);
    #1;
    RST = 1'b0;
    check("outputs after reset", 31'h0, outv);
    for (int j = 0; j < 31; j++) begin
      for (int n = 0; n < 28; n++) begin
        for (int i = 0; i < 7; i++) c[i] = rcode();
        c[n % 7] = 11'(FC[j] + 1000 * (n / 14));
        p = 7'($urandom);
        p[n % 7] = n / 7 % 2;
        step(c, p, 16'($urandom));
      end
    end
    for (int i = 0; i < 7; i++) begin
      step({7{11'h011}}, 7'(1 << i), 16'h0000);
      step({{6{11'h000}}, 11'h018}, 7'h01, 16'(1 << LB[i]));
    end
    @(posedge CLK);
    #1;
    RST = 1'b1;
    @(posedge CLK);
    #1;
    RST = 1'b0;
    repeat (3) begin
      @(posedge CLK);
      #2;
      check("outputs while warming", 31'h0, outv);
    end
    @(posedge CLK);
    #2;
    check("outputs after warm-up", model(code, pin_req, 16'h0000), outv);
    step({7{11'h007}}, 7'h7F, 16'h6004);
    complete_run();
  end
endmodule
